// ===== core/cdr_ctrl_cfg.svh
// Offsets, field positions, reset values and timing for the front-end control bank
// Contract
// (RULE1) Sample instant moves in 1/32 UI steps, only above 5.65 Gbps.
// (RULE2) Sample phase field is a signed two's complement nibble.
// (RULE3) Seven-bit slice word sets the input decision threshold.
// (RULE4) A slice word of all zeros disables the slice function.
// (RULE5) Slice top bit picks normal (0) or extended (1) slice mode.
// (RULE6) Termination float bit: 0 drives common mode, 1 floats it.
// (RULE7) Input stage: 00 limiter, 01 equalizer, 10 buffer; host never writes 11.
// (RULE8) Auto equalizer bit: 0 manual gain, 1 adaptive equalizer.
// (RULE9) Low nibble of the input stage register sets equalizer gain.
// (RULE10) Squelch bit 1 squelches the data output.
// (RULE11) Data disable bit 1 turns the data output off.
// (RULE12) Clock disable bit 1 turns the recovered clock output off.
// (RULE13) Outputs always run double data rate; that bit is reserved. The code drives double_rate 0 while reset_i is high.
// (RULE14) Data polarity bit 1 inverts output data.
// (RULE15) Clock polarity bit 1 inverts output clock.
// (RULE16) Upper swing nibble sets data amplitude, about 50 mV a step, reset 0xC.
// (RULE17) Host never writes data swing codes 0x1 to 0x3.
// (RULE18) Host writes zeros to reserved bits and ignores their read value.
// (RULE19) Writable fields read back the last written value or the default.
`ifndef CDR_CTRL_CFG_SVH
`define CDR_CTRL_CFG_SVH

// ============================================================
// Register offsets
`define OFS_SAMPLE_PHASE_OFFSET 8'h14
`define OFS_SLICE_THRESHOLD 8'h15
`define OFS_INPUT_STAGE_CONFIG 8'h16
`define OFS_OUTPUT_CONTROL 8'h1E
`define OFS_OUTPUT_SWING 8'h1F

// ============================================================
// Field positions
`define POS_PHASE_HI 3
`define POS_SLICE_EXT 7
`define POS_SLICE_HI 6
`define POS_TERM_FLOAT 7
`define POS_INSEL_HI 6
`define POS_INSEL_LO 5
`define POS_AUTO_EQ 4
`define POS_EQ_HI 3
`define POS_SQUELCH 5
`define POS_DATA_OFF 4
`define POS_CLOCK_OFF 3
`define POS_DATA_INV 1
`define POS_CLOCK_INV 0
`define POS_SWING_HI 7
`define POS_SWING_LO 4

// ============================================================
// Writable masks; reserved bits read zero
`define MASK_SAMPLE_PHASE_OFFSET 8'h0F
`define MASK_OUTPUT_CONTROL 8'h3B

// ============================================================
// Reset values
`define RST_SAMPLE_PHASE_OFFSET 8'h00
`define RST_SLICE_THRESHOLD 8'h00
`define RST_INPUT_STAGE_CONFIG 8'h00
`define RST_OUTPUT_CONTROL 8'h00
`define RST_OUTPUT_SWING 8'hCC

// ============================================================
// Management bus
`define MGMT_DEV_ADDR 7'h2A
`define MGMT_SYNC_STAGES 3

`endif

// ===== core/cdr_ctrl_pkg.sv
// Types shared by the front-end control bank
package cdr_ctrl_pkg;

    typedef enum logic [1:0] {
        stage_limiter,
        stage_equalizer,
        stage_buffer,
        stage_undefined
    } input_stage_e;

    typedef struct packed {
        logic signed [3:0] sample_phase;
        logic phase_active;
        logic [6:0] slice_level;
        logic slice_enable;
        logic slice_extended;
        logic term_float;
        input_stage_e input_stage;
        logic auto_equalizer_enable;
        logic [3:0] equalizer_gain;
        logic data_squelch;
        logic data_output_off;
        logic clock_output_off;
        logic double_rate;
        logic data_invert;
        logic clock_invert;
        logic [3:0] data_swing;
    } front_end_ctrl_s;

    typedef enum logic [3:0] {
        mgmt_idle,
        mgmt_addr,
        mgmt_addr_ack,
        mgmt_sub,
        mgmt_sub_ack,
        mgmt_write,
        mgmt_write_ack,
        mgmt_read,
        mgmt_read_ack
    } mgmt_state_e;

endpackage

// ===== core/cdr_front_end_ctrl.sv
// Front-end control registers behind the serial management bus
`timescale 1ns/1ps
`include "cdr_ctrl_cfg.svh"
module cdr_front_end_ctrl
    import cdr_ctrl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `MGMT_DEV_ADDR
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic high_rate_i,
    output front_end_ctrl_s ctrl_o
);

    // ============================================================
    // Pin synchronisation
    logic [1:0] pins_level;
    logic scl_lvl;
    logic sda_lvl;
    logic scl_prev;
    logic sda_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    pin_sync #(
        .WIDTH(2),
        .INIT(2'h3)
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .pin_i({scl_i, sda_i}),
        .level_o(pins_level)
    );

    assign scl_lvl = pins_level[1];
    assign sda_lvl = pins_level[0];

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl_lvl;
            sda_prev <= sda_lvl;
        end
    end

    assign scl_rise = scl_lvl && !scl_prev;
    assign scl_fall = !scl_lvl && scl_prev;
    assign start_seen = scl_lvl && scl_prev && sda_prev && !sda_lvl;
    assign stop_seen = scl_lvl && scl_prev && !sda_prev && sda_lvl;

    // ============================================================
    // Register storage
    logic [7:0] sample_phase_offset;
    logic [7:0] slice_threshold;
    logic [7:0] input_stage_config;
    logic [7:0] output_control;
    logic [7:0] output_swing;

    // ============================================================
    // Protocol state
    mgmt_state_e state;
    logic [7:0] shreg;
    logic [2:0] bit_cnt;
    logic byte_done;
    logic [7:0] ptr;
    logic read_dir;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    // Reserved positions read as zero
    function automatic logic [7:0] read_reg(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `OFS_SAMPLE_PHASE_OFFSET: v = sample_phase_offset;
            `OFS_SLICE_THRESHOLD: v = slice_threshold;
            `OFS_INPUT_STAGE_CONFIG: v = input_stage_config;
            `OFS_OUTPUT_CONTROL: v = output_control;
            `OFS_OUTPUT_SWING: v = output_swing;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ============================================================
    // Read data mux
    // A process, not an assign, so a register change alone re-evaluates the mux
    always_comb begin
        rd_data = read_reg(ptr);
    end

    // ============================================================
    // Protocol engine
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state <= mgmt_idle;
            shreg <= 8'h00;
            bit_cnt <= 3'h0;
            byte_done <= 1'b0;
            ptr <= 8'h00;
            read_dir <= 1'b0;
            sda_oe_o <= 1'b0;
            wr_stb <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (start_seen) begin
                // Repeated start keeps the register pointer
                state <= mgmt_addr;
                bit_cnt <= 3'h0;
                byte_done <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (stop_seen) begin
                state <= mgmt_idle;
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                unique case (state)
                    mgmt_addr, mgmt_sub, mgmt_write: begin
                        shreg <= {shreg[6:0], sda_lvl};
                        bit_cnt <= bit_cnt + 3'h1;
                        byte_done <= (bit_cnt == 3'h7);
                    end
                    mgmt_read: begin
                        bit_cnt <= bit_cnt + 3'h1;
                        byte_done <= (bit_cnt == 3'h7);
                    end
                    mgmt_read_ack: begin
                        // Controller NACK ends the read burst
                        if (sda_lvl) begin
                            state <= mgmt_idle;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                unique case (state)
                    mgmt_addr: begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            if (shreg[7:1] == DEV_ADDR) begin
                                read_dir <= shreg[0];
                                sda_oe_o <= 1'b1;
                                state <= mgmt_addr_ack;
                            end else begin
                                state <= mgmt_idle;
                            end
                        end
                    end
                    mgmt_addr_ack: begin
                        bit_cnt <= 3'h0;
                        if (read_dir) begin
                            shreg <= rd_data;
                            sda_oe_o <= !rd_data[7];
                            ptr <= ptr + 8'h01;
                            state <= mgmt_read;
                        end else begin
                            sda_oe_o <= 1'b0;
                            state <= mgmt_sub;
                        end
                    end
                    mgmt_sub: begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            ptr <= shreg;
                            sda_oe_o <= 1'b1;
                            state <= mgmt_sub_ack;
                        end
                    end
                    mgmt_write: begin
                        if (byte_done) begin
                            // Only a complete byte reaches the bank
                            byte_done <= 1'b0;
                            wr_stb <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= shreg;
                            ptr <= ptr + 8'h01;
                            sda_oe_o <= 1'b1;
                            state <= mgmt_write_ack;
                        end
                    end
                    mgmt_sub_ack, mgmt_write_ack: begin
                        bit_cnt <= 3'h0;
                        sda_oe_o <= 1'b0;
                        state <= mgmt_write;
                    end
                    mgmt_read: begin
                        if (byte_done) begin
                            byte_done <= 1'b0;
                            sda_oe_o <= 1'b0;
                            state <= mgmt_read_ack;
                        end else begin
                            shreg <= {shreg[6:0], 1'b0};
                            sda_oe_o <= !shreg[6];
                        end
                    end
                    mgmt_read_ack: begin
                        bit_cnt <= 3'h0;
                        shreg <= rd_data;
                        sda_oe_o <= !rd_data[7];
                        ptr <= ptr + 8'h01;
                        state <= mgmt_read;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Open-drain: the pin is only ever pulled low
    always_ff @(posedge mclk_i) begin
        sda_o <= 1'b0;
    end

    // ============================================================
    // Register writes; unmapped offsets are acknowledged and dropped
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sample_phase_offset <= `RST_SAMPLE_PHASE_OFFSET;
            slice_threshold <= `RST_SLICE_THRESHOLD;
            input_stage_config <= `RST_INPUT_STAGE_CONFIG;
            output_control <= `RST_OUTPUT_CONTROL;
            output_swing <= `RST_OUTPUT_SWING; // see (RULE16)
        end else if (wr_stb) begin
            unique case (wr_addr)
                `OFS_SAMPLE_PHASE_OFFSET: begin
                    sample_phase_offset <= wr_data & `MASK_SAMPLE_PHASE_OFFSET; // see (RULE19)
                end
                `OFS_SLICE_THRESHOLD: begin
                    slice_threshold <= wr_data; // see (RULE19)
                end
                `OFS_INPUT_STAGE_CONFIG: begin
                    input_stage_config <= wr_data; // see (RULE19)
                end
                `OFS_OUTPUT_CONTROL: begin
                    // Double rate bit is held at zero; it has no selectable effect
                    output_control <= wr_data & `MASK_OUTPUT_CONTROL; // see (RULE13)
                end
                `OFS_OUTPUT_SWING: begin
                    // Codes 0x1 to 0x3 are stored as written; the host must avoid them
                    output_swing <= wr_data; // see (RULE17)
                end
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // Decoded controls toward the analog stages
    front_end_ctrl_s next_ctrl;

    always_comb begin
        next_ctrl = '0;
        // Phase offset only takes effect at high data rates
        next_ctrl.phase_active = high_rate_i; // see (RULE1)
        if (high_rate_i) begin
            next_ctrl.sample_phase =
                $signed(sample_phase_offset[`POS_PHASE_HI:0]); // see (RULE1) see (RULE2)
        end else begin
            next_ctrl.sample_phase = 4'sh0;
        end
        next_ctrl.slice_level = slice_threshold[`POS_SLICE_HI:0]; // see (RULE3)
        next_ctrl.slice_enable = |slice_threshold[`POS_SLICE_HI:0]; // see (RULE4)
        next_ctrl.slice_extended = slice_threshold[`POS_SLICE_EXT]; // see (RULE5)
        next_ctrl.term_float = input_stage_config[`POS_TERM_FLOAT]; // see (RULE6)
        // Code 11 is passed on unchanged so misuse stays visible
        next_ctrl.input_stage =
            input_stage_e'(input_stage_config[`POS_INSEL_HI:`POS_INSEL_LO]); // see (RULE7)
        next_ctrl.auto_equalizer_enable = input_stage_config[`POS_AUTO_EQ]; // see (RULE8)
        next_ctrl.equalizer_gain = input_stage_config[`POS_EQ_HI:0]; // see (RULE9)
        next_ctrl.data_squelch = output_control[`POS_SQUELCH]; // see (RULE10)
        next_ctrl.data_output_off = output_control[`POS_DATA_OFF]; // see (RULE11)
        next_ctrl.clock_output_off = output_control[`POS_CLOCK_OFF]; // see (RULE12)
        next_ctrl.double_rate = 1'b1; // see (RULE13)
        next_ctrl.data_invert = output_control[`POS_DATA_INV]; // see (RULE14)
        next_ctrl.clock_invert = output_control[`POS_CLOCK_INV]; // see (RULE15)
        next_ctrl.data_swing = output_swing[`POS_SWING_HI:`POS_SWING_LO]; // see (RULE16)
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctrl_o <= '0;
        end else begin
            ctrl_o <= next_ctrl;
        end
    end

endmodule

// ===== core/pin_sync.sv
// Three-stage pin synchroniser with two-stage agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // ============================================================
    // Per-bit chain; stage1 feeds only stage2
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            always_ff @(posedge mclk_i) begin
                if (reset_i) begin
                    stage1[b] <= INIT[b];
                    stage2[b] <= INIT[b];
                    stage3[b] <= INIT[b];
                    level_o[b] <= INIT[b];
                end else begin
                    stage1[b] <= pin_i[b];
                    stage2[b] <= stage1[b];
                    stage3[b] <= stage2[b];
                    // A change counts only once two stages agree
                    if (stage2[b] == stage3[b]) begin
                        level_o[b] <= stage3[b];
                    end
                end
            end
        end
    endgenerate

endmodule

// ===== test/cdr_front_end_ctrl_checker.sv
// Port assertions for the front-end control bank
`timescale 1ns/1ps
module cdr_front_end_ctrl_checker
    import cdr_ctrl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic high_rate_i,
    input wire front_end_ctrl_s ctrl_o
);
    // ============================================================
    // Settling guard: checks wait three edges after reset release
    logic [1:0] since_rst;
    logic settled;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            since_rst <= 2'h0;
        end else if (since_rst != 2'h3) begin
            since_rst <= since_rst + 2'h1;
        end
    end
    assign settled = (since_rst == 2'h3);
    // Unknown until the first edge, so the reset check waits for a seen reset
    logic rst_prev;
    always_ff @(posedge mclk_i) begin
        rst_prev <= reset_i;
    end

    // ============================================================
    // Properties
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    property p_rst_zero;
        disable iff (1'b0) reset_i && rst_prev |-> ctrl_o == '0;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("outputs not cleared");

    property p_swing_dflt;
        $fell(reset_i) |-> ##[1:3] ctrl_o.data_swing == 4'hC;
    endproperty
    a_swing_dflt: assert property (p_swing_dflt) else $error("swing default wrong");

    property p_ddr;
        settled |-> ctrl_o.double_rate;
    endproperty
    a_ddr: assert property (p_ddr) else $error("double rate not held");

    property p_rate;
        settled |-> ctrl_o.phase_active == $past(high_rate_i);
    endproperty
    a_rate: assert property (p_rate) else $error("phase gate not following rate");

    property p_phase_gate;
        !ctrl_o.phase_active |-> ctrl_o.sample_phase == 4'h0;
    endproperty
    a_phase_gate: assert property (p_phase_gate) else $error("phase at low rate");

    property p_slice_off;
        1'b1 |-> ctrl_o.slice_enable == (ctrl_o.slice_level != 7'h00);
    endproperty
    a_slice_off: assert property (p_slice_off) else $error("slice enable wrong");

    property p_ack_low;
        $rose(sda_oe_o) |-> !scl_i && sda_o == 1'b0;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("data driven in clock high");

    // Slice level and data swing move only as a write completes, while the bus clock is low
    property p_held;
        settled && $changed({ctrl_o.slice_level, ctrl_o.data_swing}) |-> !scl_i;
    endproperty
    a_held: assert property (p_held) else $error("field changed outside write");
endmodule

bind cdr_front_end_ctrl cdr_front_end_ctrl_checker u_chk (.mclk_i(mclk_i), .reset_i(reset_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .high_rate_i(high_rate_i), .ctrl_o(ctrl_o));

// ===== test/cdr_front_end_output_control_regs_tb.sv
// Self-checking bench for the front-end control bank
`timescale 1ns/1ps
`include "cdr_ctrl_cfg.svh"
module cdr_front_end_output_control_regs_tb
    import cdr_ctrl_pkg::*;
;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic high_rate_i = 1'b0;
    logic scl, host_low, sda_o, sda_oe_o;
    wire logic sda_i;
    front_end_ctrl_s ctrl_o;
    int n_fail = 0;
    int cmp_count = 0;
    int seed = 69;
    logic [7:0] shadow [5];
    logic [7:0] ofs_tab [5] = '{`OFS_SAMPLE_PHASE_OFFSET, `OFS_SLICE_THRESHOLD,
        `OFS_INPUT_STAGE_CONFIG, `OFS_OUTPUT_CONTROL, `OFS_OUTPUT_SWING};
    logic [7:0] rst_tab [5] = '{`RST_SAMPLE_PHASE_OFFSET, `RST_SLICE_THRESHOLD,
        `RST_INPUT_STAGE_CONFIG, `RST_OUTPUT_CONTROL, `RST_OUTPUT_SWING};
    int c_idx [12] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 4, 4};
    logic [7:0] c_val [12] = '{8'h08, 8'h07, 8'h00, 8'h80, 8'h7F, 8'h1F, 8'h35, 8'hCA,
        8'h3B, 8'h20, 8'h40, 8'hF3};

    always #10 mclk_i = ~mclk_i;
    // Open-drain wire with pull-up
    assign sda_i = !(host_low | (sda_oe_o & !sda_o));

    mgmt_host u_host (.mclk_i(mclk_i), .sda_i(sda_i), .scl_o(scl), .sda_low_o(host_low));
    cdr_front_end_ctrl u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .scl_i(scl),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .high_rate_i(high_rate_i),
        .ctrl_o(ctrl_o));

    // ============================================================
    // Checking and expectations
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic front_end_ctrl_s exp_ctrl(input logic hr);
        front_end_ctrl_s e;
        e.sample_phase = hr ? shadow[0][3:0] : 4'h0;
        e.phase_active = hr;
        e.slice_level = shadow[1][6:0];
        e.slice_enable = (shadow[1][6:0] != 7'h00);
        e.slice_extended = shadow[1][7];
        e.term_float = shadow[2][7];
        e.input_stage = input_stage_e'(shadow[2][6:5]);
        e.auto_equalizer_enable = shadow[2][4];
        e.equalizer_gain = shadow[2][3:0];
        e.data_squelch = shadow[3][5];
        e.data_output_off = shadow[3][4];
        e.clock_output_off = shadow[3][3];
        e.double_rate = 1'b1;
        e.data_invert = shadow[3][1];
        e.clock_invert = shadow[3][0];
        e.data_swing = shadow[4][7:4];
        return e;
    endfunction
    task automatic rd(input logic [7:0] o, input logic [7:0] exp);
        logic ok;
        logic [7:0] d;
        u_host.read_reg(`MGMT_DEV_ADDR, o, d, ok);
        check(32'(ok), 32'h1);
        check(32'(d), 32'(exp));
    endtask
    task automatic chk_ctrl(input logic hr);
        high_rate_i <= hr;
        repeat (3) @(posedge mclk_i);
        check(ctrl_o, exp_ctrl(hr));
        check(ctrl_o, exp_ctrl(hr));
    endtask
    task automatic step(input int i, input logic [7:0] v, input logic hr);
        logic ok;
        u_host.write_reg(`MGMT_DEV_ADDR, ofs_tab[i], v, ok);
        check(32'(ok), 32'h1);
        shadow[i] = v;
        rd(ofs_tab[i], shadow[i]);
        chk_ctrl(hr);
    endtask
    task automatic do_reset();
        reset_i <= 1'b1;
        repeat (16) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        for (int k = 0; k < 5; k++) shadow[k] = rst_tab[k];
        check(32'(ctrl_o.data_swing), 32'hC);
        rd(ofs_tab[4], 8'hCC);
        chk_ctrl(1'b1);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        logic ok;
        int i;
        do_reset();
        for (int k = 0; k < 4; k++) rd(ofs_tab[k], rst_tab[k]);
        $display("test reset defaults done");
        for (int k = 0; k < 12; k++) step(c_idx[k], c_val[k], k[0]);
        $display("test corner codes done");
        for (int k = 0; k < 10; k++) begin
            i = {$random(seed)} % 5;
            step(i, u_host.legal(i, 8'($random(seed))), 1'($random(seed)));
        end
        $display("test random writes done");
        // Wrong device address is refused and leaves the bank untouched
        u_host.write_reg(`MGMT_DEV_ADDR ^ 7'h01, ofs_tab[4], 8'h50, ok);
        check(32'(ok), 32'h0);
        rd(ofs_tab[4], shadow[4]);
        rd(8'h20, 8'h00);
        $display("test refusals done");
        do_reset();
        $display("test second reset done");
        wrap_up();
    end
    initial begin
        repeat (95000) @(posedge mclk_i);
        n_fail++;
        $display("MISMATCH at %0t: run did not finish", $time);
        wrap_up();
    end
endmodule

// ===== test/mgmt_host.sv
// Management bus controller model for the control bank
`timescale 1ns/1ps
`include "cdr_ctrl_cfg.svh"
module mgmt_host #(
    parameter int HALF = 8
) (
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic pause();
        repeat (HALF) @(posedge mclk_i);
    endtask
    // One bus clock: drive b (1 releases), sample the wire with clock high
    task automatic clk_bit(input logic b, output logic s);
        sda_low_o <= !b;
        pause();
        scl_o <= 1'b1;
        pause();
        s = sda_i;
        scl_o <= 1'b0;
        pause();
    endtask
    task automatic start();
        sda_low_o <= 1'b0;
        pause();
        scl_o <= 1'b1;
        pause();
        sda_low_o <= 1'b1;
        pause();
        scl_o <= 1'b0;
        pause();
    endtask
    task automatic stop();
        sda_low_o <= 1'b1;
        pause();
        scl_o <= 1'b1;
        pause();
        sda_low_o <= 1'b0;
        pause();
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                        output logic s);
        for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
        clk_bit(ab, s);
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                             input logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic s0, s1, s2;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, s0);
        xfer(ofs, 1'b1, rx, s1);
        xfer(d, 1'b1, rx, s2);
        stop();
        ok = !(s0 | s1 | s2);
    endtask
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
                            output logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic s0, s1, s2, s3;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, s0);
        xfer(ofs, 1'b1, rx, s1);
        start();
        xfer({dev, 1'b1}, 1'b1, rx, s2);
        xfer(8'hFF, 1'b1, d, s3);
        stop();
        ok = !(s0 | s1 | s2);
    endtask
    // Values this controller is allowed to write into register slot idx
    function automatic logic [7:0] legal(input int idx, input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (idx == 0) r = v & `MASK_SAMPLE_PHASE_OFFSET;
        if (idx == 3) r = v & `MASK_OUTPUT_CONTROL;
        if (idx == 2 && r[6:5] == 2'h3) r[6] = 1'b0;
        if (idx == 4 && r[7:4] inside {4'h1, 4'h2, 4'h3}) r[7:4] = 4'h4;
        return r;
    endfunction
endmodule
